// ---- common/lgc_pkg.sv ----
// Purpose: Shared constants, types and decode functions for the link pin configuration block
// Assumes: 8-bit registers at byte offsets; one 200 MHz core clock
// Notes: Back-channel bit timing is derived from core_clk standing in for the oscillator
package lgc_pkg;
  // Register offsets
  localparam logic [7:0] LGC_ADDR_PIN9 = 8'h1A;
  localparam logic [7:0] LGC_ADDR_PIN0 = 8'h1D;
  localparam logic [7:0] LGC_ADDR_PIN12 = 8'h1E;
  localparam logic [7:0] LGC_ADDR_PIN3 = 8'h1F;
  localparam logic [7:0] LGC_ADDR_REG56 = 8'h20;
  localparam logic [7:0] LGC_ADDR_REG78 = 8'h21;
  localparam logic [7:0] LGC_ADDR_BCRATE = 8'h23;
  localparam logic [7:0] LGC_ADDR_PORTSEL = 8'h34;
  localparam logic [7:0] LGC_ADDR_CCMODE = 8'h43;
  localparam logic [7:0] LGC_ADDR_INLO = 8'h6E;
  localparam logic [7:0] LGC_ADDR_INHI = 8'h6F;
  // Field positions
  localparam int LGC_BC_DIV_SEL_BIT = 6;
  localparam int LGC_BC_FAST_BIT = 4;
  localparam int LGC_FIRST_PORT_BIT = 0;
  localparam int LGC_SECOND_PORT_BIT = 1;
  // Reset values
  localparam logic [7:0] LGC_PORTSEL_RST = 8'h01;
  localparam logic [1:0] LGC_STRAP_SETTLE = 2'h2;
  // Pin configuration nibble codes
  localparam logic [3:0] LGC_CFG_FWD_OUT = 4'h5;
  localparam logic [3:0] LGC_CFG_INPUT = 4'h3;
  localparam logic [3:0] LGC_CFG_DRIVE_LOW = 4'h1;
  localparam logic [3:0] LGC_CFG_DRIVE_HIGH = 4'h9;
  // Timing: oscillator bit period at the fastest back-channel rate
  localparam int LGC_CORE_PERIOD_NS = 5;
  localparam int LGC_OSC_PERIOD_NS = 50;
  localparam logic [3:0] LGC_OSC_DIV = 4'((LGC_OSC_PERIOD_NS + LGC_CORE_PERIOD_NS - 1)
                                          / LGC_CORE_PERIOD_NS);
  localparam logic [1:0] LGC_DIV1_LAST = 2'h0;
  localparam logic [1:0] LGC_DIV2_LAST = 2'h1;
  localparam logic [1:0] LGC_DIV4_LAST = 2'h3;
  localparam logic [4:0] LGC_FRAME_BITS = 5'h1E;
  localparam int LGC_SYNC_W = 14;

  typedef enum logic [2:0] {
    LGC_MODE_NORMAL = 3'b000,
    LGC_MODE_FAST1 = 3'b001,
    LGC_MODE_FAST2 = 3'b010,
    LGC_MODE_FAST4 = 3'b011
  } lgc_ccmode_e;

  // Bit periods between samples, so samples are evenly spread over a frame
  function automatic logic [4:0] lgc_sample_gap(input logic [2:0] mode);
    case (mode)
      LGC_MODE_NORMAL: lgc_sample_gap = 5'h1E;
      LGC_MODE_FAST4: lgc_sample_gap = 5'h05;
      LGC_MODE_FAST2: lgc_sample_gap = 5'h03;
      LGC_MODE_FAST1: lgc_sample_gap = 5'h02;
      default: lgc_sample_gap = 5'h1E;
    endcase
  endfunction

  // High-speed pins that a control-channel mode allows
  function automatic logic [3:0] lgc_hs_mask(input logic [2:0] mode);
    case (mode)
      LGC_MODE_NORMAL: lgc_hs_mask = 4'hF;
      LGC_MODE_FAST4: lgc_hs_mask = 4'hF;
      LGC_MODE_FAST2: lgc_hs_mask = 4'h3;
      LGC_MODE_FAST1: lgc_hs_mask = 4'h1;
      default: lgc_hs_mask = 4'h0;
    endcase
  endfunction

  // Returns {oe, out}; unknown codes leave the pin undriven
  function automatic logic [1:0] lgc_drive(input logic [3:0] nib, input logic fwd,
                                           input logic fwd_ok);
    case (nib)
      LGC_CFG_FWD_OUT: lgc_drive = fwd_ok ? {1'b1, fwd} : 2'b00;
      LGC_CFG_DRIVE_LOW: lgc_drive = 2'b10;
      LGC_CFG_DRIVE_HIGH: lgc_drive = 2'b11;
      default: lgc_drive = 2'b00;
    endcase
  endfunction
endpackage

// ---- core/lgc_bc_timing.sv ----
// Purpose: Back-channel bit rate, frame and sample strobes
// Assumes: Rate settings come from registers on core_clk
// Notes: Sample gaps divide the frame length exactly, so samples stay frame aligned
`timescale 1ns/10ps
`default_nettype none
module lgc_bc_timing (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic fast_en,
  input wire logic div_sel,
  input wire logic [2:0] mode,
  output logic frame_stb,
  output logic sample_stb
);
  import lgc_pkg::*;

  typedef struct packed {
    logic [3:0] osc_cnt;
    logic [1:0] div_cnt;
    logic [4:0] bit_cnt;
    logic [4:0] gap_cnt;
  } lgc_timing_s;

  lgc_timing_s st;
  lgc_timing_s next_st;
  logic [1:0] div_last;
  logic osc_tick;
  logic bit_tick;
  logic [4:0] gap;

  always_comb begin
    div_last = fast_en ? LGC_DIV1_LAST : (div_sel ? LGC_DIV2_LAST : LGC_DIV4_LAST);
    osc_tick = (st.osc_cnt == LGC_OSC_DIV - 4'h1);
    bit_tick = osc_tick && (st.div_cnt >= div_last);
    gap = lgc_sample_gap(mode);
    frame_stb = bit_tick && (st.bit_cnt == LGC_FRAME_BITS - 5'h01);
    sample_stb = bit_tick && (frame_stb || st.gap_cnt >= gap - 5'h01);
    next_st = st;
    next_st.osc_cnt = osc_tick ? 4'h0 : st.osc_cnt + 4'h1;
    if (osc_tick) begin
      next_st.div_cnt = bit_tick ? 2'h0 : st.div_cnt + 2'h1;
    end
    if (bit_tick) begin
      next_st.bit_cnt = frame_stb ? 5'h00 : st.bit_cnt + 5'h01;
      next_st.gap_cnt = sample_stb ? 5'h00 : st.gap_cnt + 5'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // lgc_bc_timing
`default_nettype wire

// ---- core/lgc_gpio_top.sv ----
// Purpose: Pin configuration, tunnelling and local pin logic of the link deserializer
// Assumes: Register accesses arrive already decoded from the local and remote control paths
// Notes: Local accesses win; the remote path waits on rem_ready
`timescale 1ns/10ps
`default_nettype none
// Function
// - Tunnelled pins act as forward-channel outputs or back-channel inputs.
// - Port-select bits choose whether config registers mean normal or fast pins.
// - Fast pins work only with two link lanes active.
// - Nibble 0x5 selects forward output, 0x3 selects back-channel input.
// - Tunnelled pins may also be read locally or driven locally.
// - Divider select picks divide by four or by two for back channel.
// - Fast back-channel bit forces divide by one; strap pin presets it.
// - Control-channel mode sets fast pin count and samples per frame.
// - Register-only pins are locally driven or read, never tunnelled.
// - Register-pin mode overrides the shared audio input.
// - Local pin state reachable by local and remote register access.
// - Local nibble: 0x1 drive low, 0x9 drive high, 0x3 input.
// - Input levels reported in the two input state registers.
// - Reduced colour mode follows the paired serializer, not software.
// - Reads return selected copy, the second port when both; writes hit all selected.
module lgc_gpio_top (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic loc_wr,
  input wire logic loc_rd,
  input wire logic [7:0] loc_addr,
  input wire logic [7:0] loc_wdata,
  input wire logic rem_wr,
  input wire logic rem_rd,
  input wire logic [7:0] rem_addr,
  input wire logic [7:0] rem_wdata,
  output logic rem_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic rd_remote,
  input wire logic two_lane,
  input wire logic remote_18bit,
  input wire logic [3:0] fwd_gpio,
  input wire logic [3:0] fwd_hs_gpio,
  input wire logic mode_strap_pin,
  input wire logic [3:0] gpio_in,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe,
  input wire logic [3:0] hs_gpio_in,
  output logic [3:0] hs_gpio_out,
  output logic [3:0] hs_gpio_oe,
  input wire logic [4:0] regpin_in,
  output logic [4:0] regpin_out,
  output logic [4:0] regpin_oe,
  output logic [3:0] audio_pin_in,
  output logic [3:0] bc_gpio,
  output logic bc_frame_stb,
  output logic [3:0] bc_hs_gpio,
  output logic bc_hs_stb,
  output logic color_18bit_mode
);
  import lgc_pkg::*;

  typedef struct packed {
    logic [1:0][7:0] pin0_config;
    logic [1:0][7:0] pin1_pin2_config;
    logic [1:0][7:0] pin3_config;
    logic [7:0] pin9_local_config;
    logic [7:0] regpin5_6_config;
    logic [7:0] regpin7_8_config;
    logic [7:0] back_channel_rate_ctl;
    logic [7:0] port_select;
    logic [7:0] control_channel_mode;
    logic [7:0] rd_data;
    logic rd_valid;
    logic rd_remote;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [3:0] gpio_out;
    logic [3:0] gpio_oe;
    logic [3:0] hs_out;
    logic [3:0] hs_oe;
    logic [4:0] reg_out;
    logic [4:0] reg_oe;
    logic [3:0] audio;
    logic [3:0] bc_gpio;
    logic bc_frame;
    logic [3:0] bc_hs;
    logic bc_hs_stb;
    logic color18;
  } lgc_state_s;

  lgc_state_s st;
  lgc_state_s next_st;
  logic [LGC_SYNC_W-1:0] sync_q;
  logic strap_s;
  logic [3:0] gpio_s;
  logic [3:0] hs_s;
  logic [4:0] reg_s;
  logic frame_stb;
  logic sample_stb;
  logic acc_wr;
  logic acc_rd;
  logic [7:0] acc_addr;
  logic [7:0] acc_wdata;
  logic rd_copy;
  logic [1:0][3:0][3:0] tun_nib;
  logic [4:0][3:0] reg_nib;
  logic [3:0] hs_allow;
  logic [3:0] in_tun;
  logic [1:0] drv;

  // Level reported only while the pin is configured as an input
  function automatic logic in_level(input logic [3:0] nib, input logic lvl);
    in_level = (nib == LGC_CFG_INPUT) && lvl;
  endfunction

  // Only the three local codes hand a shared pin over to register mode
  function automatic logic reg_mode(input logic [3:0] nib);
    reg_mode = (nib == LGC_CFG_INPUT) || (nib == LGC_CFG_DRIVE_LOW)
               || (nib == LGC_CFG_DRIVE_HIGH);
  endfunction

  lgc_pin_sync u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in({regpin_in, hs_gpio_in, gpio_in, mode_strap_pin}),
    .sync_out(sync_q)
  );

  assign strap_s = sync_q[0];
  assign gpio_s = sync_q[4:1];
  assign hs_s = sync_q[8:5];
  assign reg_s = sync_q[13:9];

  lgc_bc_timing u_timing (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .fast_en(st.back_channel_rate_ctl[LGC_BC_FAST_BIT]),
    .div_sel(st.back_channel_rate_ctl[LGC_BC_DIV_SEL_BIT]),
    .mode(st.control_channel_mode[2:0]),
    .frame_stb(frame_stb),
    .sample_stb(sample_stb)
  );

  // Local requests take the register port first; remote ones wait
  assign rem_ready = !(loc_wr || loc_rd);
  assign acc_wr = loc_wr || (rem_wr && rem_ready);
  assign acc_rd = loc_rd || (rem_rd && rem_ready);
  assign acc_addr = (loc_wr || loc_rd) ? loc_addr : rem_addr;
  assign acc_wdata = (loc_wr || loc_rd) ? loc_wdata : rem_wdata;
  assign rd_copy = st.port_select[LGC_SECOND_PORT_BIT];

  always_comb begin
    // Copy 0 configures the normal pins, copy 1 the fast pins
    for (int c = 0; c < 2; c++) begin
      tun_nib[c][0] = st.pin0_config[c][3:0];
      tun_nib[c][1] = st.pin1_pin2_config[c][3:0];
      tun_nib[c][2] = st.pin1_pin2_config[c][7:4];
      tun_nib[c][3] = st.pin3_config[c][3:0];
    end
    reg_nib[0] = st.regpin5_6_config[3:0];
    reg_nib[1] = st.regpin5_6_config[7:4];
    reg_nib[2] = st.regpin7_8_config[3:0];
    reg_nib[3] = st.regpin7_8_config[7:4];
    reg_nib[4] = st.pin9_local_config[3:0];
    hs_allow = two_lane ? lgc_hs_mask(st.control_channel_mode[2:0]) : 4'h0;
    for (int i = 0; i < 4; i++) begin
      in_tun[i] = rd_copy ? (tun_nib[1][i] == LGC_CFG_INPUT) && hs_allow[i] && hs_s[i]
                          : (tun_nib[0][i] == LGC_CFG_INPUT) && gpio_s[i];
    end
  end

  always_comb begin
    next_st = st;
    drv = 2'b00;
    next_st.rd_valid = 1'b0;
    next_st.bc_frame = frame_stb;
    next_st.bc_hs_stb = 1'b0;
    next_st.color18 = remote_18bit;
    // Strap is taken once, after the synchroniser output has settled
    if (!st.strap_done) begin
      next_st.strap_cnt = st.strap_cnt + 2'h1;
      if (st.strap_cnt == LGC_STRAP_SETTLE) begin
        next_st.strap_done = 1'b1;
        next_st.back_channel_rate_ctl[LGC_BC_FAST_BIT] = strap_s;
      end
    end
    if (acc_wr) begin
      case (acc_addr)
        LGC_ADDR_PIN0: begin
          for (int c = 0; c < 2; c++) begin
            if (st.port_select[c]) begin
              next_st.pin0_config[c] = acc_wdata;
            end
          end
        end
        LGC_ADDR_PIN12: begin
          for (int c = 0; c < 2; c++) begin
            if (st.port_select[c]) begin
              next_st.pin1_pin2_config[c] = acc_wdata;
            end
          end
        end
        LGC_ADDR_PIN3: begin
          for (int c = 0; c < 2; c++) begin
            if (st.port_select[c]) begin
              next_st.pin3_config[c] = acc_wdata;
            end
          end
        end
        LGC_ADDR_PIN9: next_st.pin9_local_config = acc_wdata;
        LGC_ADDR_REG56: next_st.regpin5_6_config = acc_wdata;
        LGC_ADDR_REG78: next_st.regpin7_8_config = acc_wdata;
        LGC_ADDR_BCRATE: next_st.back_channel_rate_ctl = acc_wdata;
        LGC_ADDR_PORTSEL: next_st.port_select = {6'h00, acc_wdata[1:0]};
        LGC_ADDR_CCMODE: next_st.control_channel_mode = {5'h00, acc_wdata[2:0]};
        default: next_st.rd_remote = st.rd_remote;
      endcase
    end
    if (acc_rd) begin
      next_st.rd_valid = 1'b1;
      next_st.rd_remote = !(loc_wr || loc_rd);
      case (acc_addr)
        LGC_ADDR_PIN0: next_st.rd_data = st.pin0_config[rd_copy];
        LGC_ADDR_PIN12: next_st.rd_data = st.pin1_pin2_config[rd_copy];
        LGC_ADDR_PIN3: next_st.rd_data = st.pin3_config[rd_copy];
        LGC_ADDR_PIN9: next_st.rd_data = st.pin9_local_config;
        LGC_ADDR_REG56: next_st.rd_data = st.regpin5_6_config;
        LGC_ADDR_REG78: next_st.rd_data = st.regpin7_8_config;
        LGC_ADDR_BCRATE: next_st.rd_data = st.back_channel_rate_ctl;
        LGC_ADDR_PORTSEL: next_st.rd_data = st.port_select;
        LGC_ADDR_CCMODE: next_st.rd_data = st.control_channel_mode;
        LGC_ADDR_INLO: begin
          next_st.rd_data[3:0] = in_tun;
          next_st.rd_data[4] = 1'b0;
          for (int j = 0; j < 3; j++) begin
            next_st.rd_data[5 + j] = in_level(reg_nib[j], reg_s[j]);
          end
        end
        LGC_ADDR_INHI: begin
          next_st.rd_data = 8'h00;
          next_st.rd_data[0] = in_level(reg_nib[3], reg_s[3]);
          next_st.rd_data[1] = in_level(reg_nib[4], reg_s[4]);
        end
        default: next_st.rd_data = 8'h00;
      endcase
    end
    // Pin drives are registered so every pad changes on a clock edge
    for (int i = 0; i < 4; i++) begin
      drv = lgc_drive(tun_nib[0][i], fwd_gpio[i], 1'b1);
      next_st.gpio_oe[i] = drv[1];
      next_st.gpio_out[i] = drv[0];
      drv = lgc_drive(tun_nib[1][i], fwd_hs_gpio[i], 1'b1);
      next_st.hs_oe[i] = drv[1] && hs_allow[i];
      next_st.hs_out[i] = drv[0] && hs_allow[i];
      if (frame_stb) begin
        next_st.bc_gpio[i] = in_level(tun_nib[0][i], gpio_s[i]);
      end
      if (sample_stb) begin
        next_st.bc_hs[i] = in_level(tun_nib[1][i], hs_allow[i] && hs_s[i]);
      end
    end
    if (sample_stb && (hs_allow != 4'h0)) begin
      next_st.bc_hs_stb = 1'b1;
    end
    for (int j = 0; j < 5; j++) begin
      // Forward code is refused here: these pins never cross the link
      drv = lgc_drive(reg_nib[j], 1'b0, 1'b0);
      next_st.reg_oe[j] = drv[1];
      next_st.reg_out[j] = drv[0];
    end
    for (int j = 0; j < 4; j++) begin
      next_st.audio[j] = reg_s[j] && !reg_mode(reg_nib[j]);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      // Only the first port copy is selected out of reset
      st.port_select <= LGC_PORTSEL_RST;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd_data;
  assign rd_valid = st.rd_valid;
  assign rd_remote = st.rd_remote;
  assign gpio_out = st.gpio_out;
  assign gpio_oe = st.gpio_oe;
  assign hs_gpio_out = st.hs_out;
  assign hs_gpio_oe = st.hs_oe;
  assign regpin_out = st.reg_out;
  assign regpin_oe = st.reg_oe;
  assign audio_pin_in = st.audio;
  assign bc_gpio = st.bc_gpio;
  assign bc_frame_stb = st.bc_frame;
  assign bc_hs_gpio = st.bc_hs;
  assign bc_hs_stb = st.bc_hs_stb;
  assign color_18bit_mode = st.color18;
endmodule // lgc_gpio_top
`default_nettype wire

// ---- core/lgc_pin_sync.sv ----
// Purpose: Two-stage synchroniser for all pin inputs
// Assumes: Inputs are asynchronous to core_clk
// Notes: Only the second stage is visible outside
`timescale 1ns/10ps
`default_nettype none
module lgc_pin_sync (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [lgc_pkg::LGC_SYNC_W-1:0] async_in,
  output logic [lgc_pkg::LGC_SYNC_W-1:0] sync_out
);
  import lgc_pkg::*;

  typedef struct packed {
    logic [LGC_SYNC_W-1:0] stage1;
    logic [LGC_SYNC_W-1:0] stage2;
  } lgc_sync_s;

  lgc_sync_s st;
  lgc_sync_s next_st;

  always_comb begin
    next_st = st;
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stage2;
endmodule // lgc_pin_sync
`default_nettype wire

// ---- verification/lgc_gpio_chk.sv ----
// Purpose: Port-level assertions for the link pin configuration block
// Assumes: One core_clk domain, rst_b active low
// Notes: Bound to every lgc_gpio_top instance
`timescale 1ns/10ps
`default_nettype none
module lgc_gpio_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic loc_wr,
  input wire logic loc_rd,
  input wire logic rem_rd,
  input wire logic rem_ready,
  input wire logic rd_valid,
  input wire logic rd_remote,
  input wire logic two_lane,
  input wire logic remote_18bit,
  input wire logic [3:0] hs_gpio_oe,
  input wire logic [4:0] regpin_oe,
  input wire logic [3:0] audio_pin_in,
  input wire logic bc_frame_stb,
  input wire logic color_18bit_mode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  rem_hold_a: assert property ((loc_wr || loc_rd) |-> !rem_ready)
    else $error("remote path open during local access");
  loc_read_a: assert property (loc_rd |=> rd_valid && !rd_remote)
    else $error("local read answer missing");
  rem_read_a: assert property ((rem_rd && rem_ready) |=> rd_valid && rd_remote)
    else $error("remote read answer missing");
  valid_cause_a: assert property (rd_valid |-> $past(loc_rd || (rem_rd && rem_ready)))
    else $error("read answer without request");
  lane_gate_a: assert property (!two_lane |=> hs_gpio_oe == 4'h0)
    else $error("fast pin driven on one lane");
  color_copy_a: assert property (1'b1 |=> color_18bit_mode == $past(remote_18bit))
    else $error("reduced colour mode not following serializer");
  frame_gap_a: assert property (bc_frame_stb |=> !bc_frame_stb [*8])
    else $error("frame strobes too close");
  audio_over_a: assert property (|regpin_oe[3:0] |-> (audio_pin_in & regpin_oe[3:0]) == 4'h0)
    else $error("audio input seen on register pin");
endmodule // lgc_gpio_chk
bind lgc_gpio_top lgc_gpio_chk i_lgc_gpio_chk (.core_clk(core_clk), .rst_b(rst_b),
  .loc_wr(loc_wr), .loc_rd(loc_rd), .rem_rd(rem_rd), .rem_ready(rem_ready),
  .rd_valid(rd_valid), .rd_remote(rd_remote), .two_lane(two_lane),
  .remote_18bit(remote_18bit), .hs_gpio_oe(hs_gpio_oe), .regpin_oe(regpin_oe),
  .audio_pin_in(audio_pin_in), .bc_frame_stb(bc_frame_stb),
  .color_18bit_mode(color_18bit_mode));
`default_nettype wire

// ---- verification/lgc_ser_model.sv ----
// Purpose: Paired serializer side of the control channel
// Assumes: Requests change on the falling edge
// Notes: Released address and data show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module lgc_ser_model (
  input wire logic core_clk,
  input wire logic rem_ready,
  input wire logic [7:0] rd_data,
  output logic rem_wr,
  output logic rem_rd,
  output logic [7:0] rem_addr,
  output logic [7:0] rem_wdata
);
  initial begin
    rem_wr = 1'b0;
    rem_rd = 1'b0;
    rem_addr = 8'h00;
    rem_wdata = 8'h00;
  end
  // Held until rem_ready is seen high at a rising edge
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge core_clk);
    rem_wr = wr;
    rem_rd = !wr;
    rem_addr = a;
    rem_wdata = d;
    @(posedge core_clk);
    while (!rem_ready) begin
      @(posedge core_clk);
    end
    @(negedge core_clk);
    q = rd_data;
    rem_wr = 1'b0;
    rem_rd = 1'b0;
    rem_addr = ~a;
    rem_wdata = ~d;
  endtask
endmodule // lgc_ser_model
`default_nettype wire

// ---- verification/test_link_gpio_config.sv ----
// Purpose: Self-checking bench for the link pin configuration block
// Assumes: Local register accesses driven on the falling edge
// Notes: Strap pin held high through reset, so the fast back channel is preset
`timescale 1ns/10ps
`default_nettype none
module test_link_gpio_config;
  import lgc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic loc_wr = 1'b0;
  logic loc_rd = 1'b0;
  logic [7:0] loc_addr = 8'h00;
  logic [7:0] loc_wdata = 8'h00;
  logic two_lane = 1'b0;
  logic remote_18bit = 1'b0;
  logic [3:0] fwd_gpio = 4'h0;
  logic [3:0] fwd_hs_gpio = 4'h0;
  logic mode_strap_pin = 1'b1;
  logic [3:0] gpio_in = 4'h0;
  logic [3:0] hs_gpio_in = 4'h0;
  logic [4:0] regpin_in = 5'h00;
  logic rem_wr, rem_rd, rem_ready, rd_valid, rd_remote, bc_frame_stb, bc_hs_stb;
  logic color_18bit_mode;
  logic [7:0] rem_addr, rem_wdata, rd_data, q, qr;
  logic [3:0] gpio_out, gpio_oe, hs_gpio_out, hs_gpio_oe, audio_pin_in, bc_gpio, bc_hs_gpio;
  logic [4:0] regpin_out, regpin_oe;
  logic [3:0] cd [5] = '{4'h5, 4'h1, 4'h9, 4'h3, 4'h7};
  logic [1:0] ex [5] = '{2'b10, 2'b10, 2'b11, 2'b00, 2'b00};
  logic [2:0] md [4] = '{3'h0, 3'h3, 3'h2, 3'h1};
  logic [3:0] mk [4] = '{4'hF, 4'hF, 4'h3, 4'h1};
  int sg [4] = '{300, 50, 30, 20};
  int n_fail = 0;
  int num_checks = 0;

  always #2.5 core_clk = ~core_clk;

  lgc_gpio_top i_lgc_gpio_top (.core_clk, .rst_b, .loc_wr, .loc_rd, .loc_addr, .loc_wdata,
    .rem_wr, .rem_rd, .rem_addr, .rem_wdata, .rem_ready, .rd_data, .rd_valid, .rd_remote,
    .two_lane, .remote_18bit, .fwd_gpio, .fwd_hs_gpio, .mode_strap_pin, .gpio_in,
    .gpio_out, .gpio_oe, .hs_gpio_in, .hs_gpio_out, .hs_gpio_oe, .regpin_in, .regpin_out,
    .regpin_oe, .audio_pin_in, .bc_gpio, .bc_frame_stb, .bc_hs_gpio, .bc_hs_stb,
    .color_18bit_mode);
  lgc_ser_model i_lgc_ser_model (.core_clk, .rem_ready, .rd_data, .rem_wr, .rem_rd,
    .rem_addr, .rem_wdata);

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] got);
    num_checks++;
    if (got !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, got);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    loc_wr = 1'b1;
    loc_addr = a;
    loc_wdata = d;
    @(negedge core_clk);
    loc_wr = 1'b0;
    loc_addr = ~a;
    loc_wdata = ~d;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    loc_rd = 1'b1;
    loc_addr = a;
    @(negedge core_clk);
    chk("rd_valid", 8'h01, {7'h00, rd_valid});
    chk($sformatf("reg %h", a), e, rd_data);
    loc_rd = 1'b0;
    loc_addr = ~a;
  endtask
  // First waits for a frame strobe, after which samples are frame aligned, then times strobes
  task automatic gap(input logic hs, input int e);
    int n;
    n = 0;
    for (int k = 0; k < 3; k++) begin
      @(negedge core_clk);
      n = 1;
      while (!((hs && k > 0) ? bc_hs_stb : bc_frame_stb) && n < 4000) begin
        @(negedge core_clk);
        n++;
      end
    end
    num_checks++;
    if (n != e) begin
      $display("[ERR] strobe gap expected %0d seen %0d", e, n);
      n_fail++;
    end
  endtask
  task automatic done_t(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Tests need under 10k cycles; the 80k-cycle limit leaves ample margin
  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (4) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (5) @(negedge core_clk);
    mode_strap_pin = 1'b0;
    rc(LGC_ADDR_PORTSEL, 8'h01);
    rc(LGC_ADDR_BCRATE, 8'h10);
    rc(LGC_ADDR_CCMODE, 8'h00);
    rc(8'h00, 8'h00);
    wr(LGC_ADDR_PORTSEL, 8'hFF);
    rc(LGC_ADDR_PORTSEL, 8'h03);
    wr(LGC_ADDR_CCMODE, 8'hFF);
    rc(LGC_ADDR_CCMODE, 8'h07);
    done_t("reset and masks");
    wr(LGC_ADDR_PORTSEL, 8'h01);
    wr(LGC_ADDR_PIN12, 8'h35);
    wr(LGC_ADDR_PORTSEL, 8'h02);
    wr(LGC_ADDR_PIN12, 8'h91);
    wr(LGC_ADDR_PORTSEL, 8'h03);
    rc(LGC_ADDR_PIN12, 8'h91);
    wr(LGC_ADDR_PIN3, 8'h09);
    wr(LGC_ADDR_PORTSEL, 8'h01);
    rc(LGC_ADDR_PIN12, 8'h35);
    rc(LGC_ADDR_PIN3, 8'h09);
    wr(LGC_ADDR_PORTSEL, 8'h02);
    rc(LGC_ADDR_PIN3, 8'h09);
    done_t("port copies");
    wr(LGC_ADDR_PORTSEL, 8'h01);
    fwd_gpio = 4'hE;
    foreach (cd[i]) begin
      wr(LGC_ADDR_PIN0, {4'h0, cd[i]});
      repeat (2) @(negedge core_clk);
      chk("pin0 drive", {6'h00, ex[i]}, {6'h00, gpio_oe[0], gpio_out[0]});
    end
    wr(LGC_ADDR_PIN0, 8'h05);
    fwd_gpio = 4'h1;
    repeat (2) @(negedge core_clk);
    chk("pin0 follow", 8'h03, {6'h00, gpio_oe[0], gpio_out[0]});
    done_t("pin codes");
    gpio_in = 4'hA;
    regpin_in = 5'h15;
    wr(LGC_ADDR_PIN0, 8'h03);
    wr(LGC_ADDR_PIN12, 8'h33);
    wr(LGC_ADDR_PIN3, 8'h03);
    wr(LGC_ADDR_REG56, 8'h33);
    wr(LGC_ADDR_REG78, 8'h33);
    wr(LGC_ADDR_PIN9, 8'h03);
    wr(LGC_ADDR_INLO, 8'h00);
    rc(LGC_ADDR_INLO, 8'hAA);
    rc(LGC_ADDR_INHI, 8'h02);
    chk("audio", 8'h00, {4'h0, audio_pin_in});
    wr(LGC_ADDR_REG56, 8'h77);
    wr(LGC_ADDR_REG78, 8'h19);
    repeat (2) @(negedge core_clk);
    chk("audio", 8'h01, {4'h0, audio_pin_in});
    chk("regpin_oe", 8'h0C, {3'h0, regpin_oe});
    chk("regpin_out", 8'h04, {3'h0, regpin_out & regpin_oe});
    done_t("inputs and register pins");
    wr(LGC_ADDR_CCMODE, 8'h00);
    wr(LGC_ADDR_PORTSEL, 8'h02);
    fwd_hs_gpio = 4'hF;
    wr(LGC_ADDR_PIN0, 8'h05);
    wr(LGC_ADDR_PIN12, 8'h55);
    wr(LGC_ADDR_PIN3, 8'h05);
    repeat (2) @(negedge core_clk);
    chk("hs_oe one lane", 8'h00, {4'h0, hs_gpio_oe});
    two_lane = 1'b1;
    foreach (md[i]) begin
      wr(LGC_ADDR_CCMODE, {5'h00, md[i]});
      repeat (2) @(negedge core_clk);
      chk("hs_oe", {4'h0, mk[i]}, {4'h0, hs_gpio_oe});
      chk("hs_out", {4'h0, mk[i]}, {4'h0, hs_gpio_out & hs_gpio_oe});
      gap(1'b1, sg[i]);
    end
    hs_gpio_in = 4'hF;
    wr(LGC_ADDR_PIN0, 8'h03);
    wr(LGC_ADDR_PIN12, 8'h33);
    wr(LGC_ADDR_PIN3, 8'h03);
    rc(LGC_ADDR_INLO, 8'h01);
    gap(1'b1, 20);
    chk("bc_hs_gpio", 8'h01, {4'h0, bc_hs_gpio});
    done_t("fast pins");
    wr(LGC_ADDR_CCMODE, 8'h00);
    gap(1'b0, 300);
    chk("bc_gpio", 8'h0A, {4'h0, bc_gpio});
    wr(LGC_ADDR_BCRATE, 8'h40);
    gap(1'b0, 600);
    wr(LGC_ADDR_BCRATE, 8'h00);
    gap(1'b0, 1200);
    wr(LGC_ADDR_BCRATE, 8'h50);
    gap(1'b0, 300);
    done_t("back channel rate");
    fork
      wr(LGC_ADDR_REG56, 8'h11);
      i_lgc_ser_model.access(1'b1, LGC_ADDR_REG78, 8'h99, qr);
    join
    i_lgc_ser_model.access(1'b0, LGC_ADDR_REG78, 8'h00, qr);
    chk("remote read", 8'h99, qr);
    chk("rd_remote", 8'h01, {7'h00, rd_remote});
    rc(LGC_ADDR_REG56, 8'h11);
    remote_18bit = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("color mode", 8'h01, {7'h00, color_18bit_mode});
    done_t("remote access and colour");
    print_verdict();
  end
endmodule // test_link_gpio_config
`default_nettype wire
